// ==== verilog/flic_cfg.svh ====
// Purpose: constants for the four-level interrupt controller
// Assumes: one machine cycle per clock, phase input marks the sample point
// Notes: vectors, bit positions and reset values
`ifndef FLIC_CFG_SVH
`define FLIC_CFG_SVH
`define FLIC_NSRC 6
`define FLIC_SRC_EXA 0
`define FLIC_SRC_TMA 1
`define FLIC_SRC_EXB 2
`define FLIC_SRC_TMB 3
`define FLIC_SRC_SER 4
`define FLIC_SRC_TMC 5
`define FLIC_GLOBAL_EN 7
`define FLIC_VEC_EXA 8'h03
`define FLIC_VEC_TMA 8'h0b
`define FLIC_VEC_EXB 8'h13
`define FLIC_VEC_TMB 8'h1b
`define FLIC_VEC_SER 8'h23
`define FLIC_VEC_TMC 8'h2b
`define FLIC_NO_SRC 3'h7
`define FLIC_CALL_CYCLES 2'h2
`define FLIC_LVL_NONE 5'h00
`endif

// ==== verilog/flic_pkg.sv ====
// Purpose: types for the four-level interrupt controller
// Assumes: nothing
// Notes: call sequencer states
package flic_pkg;
  typedef enum logic [1:0] {
    FLIC_IDLE = 2'h0,
    FLIC_CALL1 = 2'h1,
    FLIC_CALL2 = 2'h3
  } flic_state_t;
  typedef logic [1:0] flic_level_t;
endpackage : flic_pkg

// ==== verilog/flic_ext_sampler.sv ====
// Purpose: sample one active-low external request pin into its flag
// Assumes: pin synchronous to CORE_CLK
// Notes: level or edge mode per trigger_type_bit
`timescale 1ns/1ps
module flic_ext_sampler (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_phase,
  input wire logic pin_n,
  input wire logic trigger_type_bit,
  input wire logic hw_clear,
  output logic request_flag
);
  logic prev_q;
  logic flag_q;

  // ---------------------------------------------
  // sample point
  // ---------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_q <= 1'b1;
    end
    else if (sample_phase)
    begin
      prev_q <= pin_n;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_q <= 1'b0;
    end
    else if (sample_phase && !trigger_type_bit)
    begin
      flag_q <= ~pin_n;
    end
    else if (sample_phase && prev_q && !pin_n)
    begin
      flag_q <= 1'b1;
    end
    else if (hw_clear && trigger_type_bit)
    begin
      flag_q <= 1'b0;
    end
  end

  assign request_flag = flag_q;

  AST_EDGE_SETS: assert property (@(posedge clk) disable iff (rst)
    (sample_phase && trigger_type_bit && prev_q && !pin_n) |=> flag_q)
    else $error("edge sample did not set flag");
  AST_LEVEL_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
    (sample_phase && !trigger_type_bit) |=> (flag_q == !$past(pin_n)))
    else $error("level flag does not follow inverted pin");
endmodule : flic_ext_sampler

// ==== verilog/flic_ctrl.sv ====
// Purpose: four-level nested interrupt controller beside the sequencer
// Assumes: one clock edge per machine cycle; SAMPLE_PHASE marks late-cycle sampling
// Notes: polls latched flags each cycle, issues a two-cycle vectored call
// Functional notes
// - inverted external pins latched late each cycle, polled next cycle
// - active unblocked request starts a hardware call lasting two cycles
// - at least three cycles from external request to service start
// - not-last-cycle blocking adds at most three cycles
// - return or enable/priority write lets one more instruction run first; hold_q also blocks at that one's last cycle, so two run
// - single-source latency above three and below nine cycles
// - level is high bit over low bit: 00 lowest, 11 highest
// - equal or higher level in service holds a request waiting
// - higher level preempts; preempted routine resumes after return
// - fixed polling order within level, vectors 03h to 2bh
// - vectoring clears timer a/b flags, external flag only if edge mode
// - trigger bit 0 low level, 1 high-then-low sets flag
// - block on active level, not-last cycle, return or register write
// - return-from-interrupt clears top in-progress level; plain return does not
`timescale 1ns/1ps
`include "flic_cfg.svh"
module flic_ctrl (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // external pins and timing
  input wire logic EXT_REQUEST_PIN_A_N,
  input wire logic EXT_REQUEST_PIN_B_N,
  input wire logic SAMPLE_PHASE,
  // configuration
  input wire logic [7:0] SOURCE_ENABLE_REG,
  input wire logic [5:0] LOW_PRIORITY_REG,
  input wire logic [5:0] HIGH_PRIORITY_REG,
  input wire logic [1:0] TRIGGER_TYPE_BIT,
  // peripheral flags
  input wire logic TIMER_A_OVERFLOW_FLAG,
  input wire logic TIMER_B_OVERFLOW_FLAG,
  input wire logic TIMER_C_OVERFLOW_FLAG,
  input wire logic TIMER_C_EXTERNAL_FLAG,
  input wire logic SERIAL_RECEIVE_FLAG,
  input wire logic SERIAL_TRANSMIT_FLAG,
  // sequencer status
  input wire logic LAST_CYCLE,
  input wire logic RETURN_FROM_INTERRUPT,
  input wire logic ENABLE_PRIO_ACCESS,
  // sequencer control
  output logic CALL_ACTIVE,
  output logic CALL_DONE,
  output logic [7:0] VECTOR_ADDR,
  output logic CLEAR_TIMER_A,
  output logic CLEAR_TIMER_B,
  // status
  output logic EXT_A_REQUEST_FLAG,
  output logic EXT_B_REQUEST_FLAG,
  output logic [3:0] LEVEL_IN_SERVICE
);
  flic_pkg::flic_state_t state_q;
  logic ext_a_flag;
  logic ext_b_flag;
  logic clr_ext_a_q;
  logic clr_ext_b_q;
  logic [`FLIC_NSRC-1:0] req;
  logic [3:0] in_service_q;
  logic hold_q;
  logic [2:0] win_src;
  flic_pkg::flic_level_t win_lvl;
  logic block;
  logic [7:0] vec_q;

  function automatic flic_pkg::flic_level_t src_level(input logic hi, input logic lo);
    src_level = {hi, lo};
  endfunction : src_level

  function automatic logic [7:0] src_vector(input logic [2:0] s);
    case (s)
      3'h0: src_vector = `FLIC_VEC_EXA;
      3'h1: src_vector = `FLIC_VEC_TMA;
      3'h2: src_vector = `FLIC_VEC_EXB;
      3'h3: src_vector = `FLIC_VEC_TMB;
      3'h4: src_vector = `FLIC_VEC_SER;
      default: src_vector = `FLIC_VEC_TMC;
    endcase
  endfunction : src_vector

  // ---------------------------------------------
  // external request sampling
  // ---------------------------------------------
  flic_ext_sampler u_ext_a (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .sample_phase(SAMPLE_PHASE),
    .pin_n(EXT_REQUEST_PIN_A_N),
    .trigger_type_bit(TRIGGER_TYPE_BIT[0]),
    .hw_clear(clr_ext_a_q),
    .request_flag(ext_a_flag)
  );
  flic_ext_sampler u_ext_b (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .sample_phase(SAMPLE_PHASE),
    .pin_n(EXT_REQUEST_PIN_B_N),
    .trigger_type_bit(TRIGGER_TYPE_BIT[1]),
    .hw_clear(clr_ext_b_q),
    .request_flag(ext_b_flag)
  );

  // ---------------------------------------------
  // polling and priority
  // ---------------------------------------------
  always_comb
  begin
    req[`FLIC_SRC_EXA] = ext_a_flag;
    req[`FLIC_SRC_TMA] = TIMER_A_OVERFLOW_FLAG;
    req[`FLIC_SRC_EXB] = ext_b_flag;
    req[`FLIC_SRC_TMB] = TIMER_B_OVERFLOW_FLAG;
    req[`FLIC_SRC_SER] = SERIAL_RECEIVE_FLAG | SERIAL_TRANSMIT_FLAG;
    req[`FLIC_SRC_TMC] = TIMER_C_OVERFLOW_FLAG | TIMER_C_EXTERNAL_FLAG;
    req = req & SOURCE_ENABLE_REG[`FLIC_NSRC-1:0]
      & {`FLIC_NSRC{SOURCE_ENABLE_REG[`FLIC_GLOBAL_EN]}};
  end

  always_comb
  begin
    win_src = `FLIC_NO_SRC;
    win_lvl = 2'h0;
    for (int s = `FLIC_NSRC - 1; s >= 0; s--)
    begin
      if (req[s] && (win_src == `FLIC_NO_SRC
          || src_level(HIGH_PRIORITY_REG[s], LOW_PRIORITY_REG[s]) >= win_lvl))
      begin
        win_src = 3'(s);
        win_lvl = src_level(HIGH_PRIORITY_REG[s], LOW_PRIORITY_REG[s]);
      end
    end
  end

  // equal or higher level active, not last cycle, or return/register access
  assign block = (win_src == `FLIC_NO_SRC)
    || ((in_service_q >> win_lvl) != 4'h0)
    || !LAST_CYCLE || hold_q
    || RETURN_FROM_INTERRUPT || ENABLE_PRIO_ACCESS;

  // ---------------------------------------------
  // one extra instruction after return or register access
  // ---------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      hold_q <= 1'b0;
    end
    else if (LAST_CYCLE && (RETURN_FROM_INTERRUPT || ENABLE_PRIO_ACCESS))
    begin
      hold_q <= 1'b1;
    end
    else if (LAST_CYCLE)
    begin
      hold_q <= 1'b0;
    end
  end

  // ---------------------------------------------
  // call sequencer
  // ---------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_q <= flic_pkg::FLIC_IDLE;
    end
    else
    begin
      unique case (state_q)
        flic_pkg::FLIC_IDLE: if (!block) state_q <= flic_pkg::FLIC_CALL1;
        flic_pkg::FLIC_CALL1: state_q <= flic_pkg::FLIC_CALL2;
        flic_pkg::FLIC_CALL2: state_q <= flic_pkg::FLIC_IDLE;
        default: state_q <= flic_pkg::FLIC_IDLE;
      endcase
    end
  end

  wire take = (state_q == flic_pkg::FLIC_IDLE) && !block;

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      vec_q <= 8'h00;
      clr_ext_a_q <= 1'b0;
      clr_ext_b_q <= 1'b0;
      CLEAR_TIMER_A <= 1'b0;
      CLEAR_TIMER_B <= 1'b0;
    end
    else
    begin
      if (take)
      begin
        vec_q <= src_vector(win_src);
      end
      clr_ext_a_q <= take && (win_src == `FLIC_SRC_EXA);
      clr_ext_b_q <= take && (win_src == `FLIC_SRC_EXB);
      CLEAR_TIMER_A <= take && (win_src == `FLIC_SRC_TMA);
      CLEAR_TIMER_B <= take && (win_src == `FLIC_SRC_TMB);
    end
  end

  // ---------------------------------------------
  // in-service levels
  // ---------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      in_service_q <= 4'h0;
    end
    else if (take)
    begin
      in_service_q <= in_service_q | (4'h1 << win_lvl);
    end
    else if (RETURN_FROM_INTERRUPT && LAST_CYCLE)
    begin
      if (in_service_q[3]) in_service_q[3] <= 1'b0;
      else if (in_service_q[2]) in_service_q[2] <= 1'b0;
      else if (in_service_q[1]) in_service_q[1] <= 1'b0;
      else in_service_q[0] <= 1'b0;
    end
  end

  // ---------------------------------------------
  // registered outputs
  // ---------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      CALL_ACTIVE <= 1'b0;
      CALL_DONE <= 1'b0;
      VECTOR_ADDR <= 8'h00;
      EXT_A_REQUEST_FLAG <= 1'b0;
      EXT_B_REQUEST_FLAG <= 1'b0;
      LEVEL_IN_SERVICE <= 4'h0;
    end
    else
    begin
      CALL_ACTIVE <= take || (state_q == flic_pkg::FLIC_CALL1);
      CALL_DONE <= (state_q == flic_pkg::FLIC_CALL1);
      VECTOR_ADDR <= take ? src_vector(win_src) : vec_q;
      EXT_A_REQUEST_FLAG <= ext_a_flag;
      EXT_B_REQUEST_FLAG <= ext_b_flag;
      LEVEL_IN_SERVICE <= in_service_q;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  sequence s_call;
    CALL_ACTIVE ##1 (CALL_ACTIVE && CALL_DONE);
  endsequence
  AST_CALL_TWO: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (take ##1 1'b1) |-> s_call ##1 !CALL_ACTIVE)
    else $error("call did not last two cycles");
  AST_NO_CALL_MIDINSTR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(CALL_ACTIVE) |-> $past(LAST_CYCLE))
    else $error("vectored outside last cycle");
  AST_HOLD_AFTER_RET: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (LAST_CYCLE && RETURN_FROM_INTERRUPT) |=> !take)
    else $error("vectored right after return");
  AST_NO_EQUAL_PREEMPT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    take |-> ((in_service_q >> win_lvl) == 4'h0))
    else $error("preempted by equal or lower level");
  AST_LEVEL_MARK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    take |=> in_service_q[$past(win_lvl)])
    else $error("level not marked in service");
  AST_TIMER_CLEAR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (take && win_src == `FLIC_SRC_TMA) |=> CLEAR_TIMER_A ##1 !CLEAR_TIMER_A)
    else $error("timer a clear pulse wrong");
  AST_ENABLE_GATE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(CALL_ACTIVE) |-> $past(SOURCE_ENABLE_REG[`FLIC_GLOBAL_EN]))
    else $error("vectored with global enable off");
  AST_VECTOR_EXA: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (take && win_src == `FLIC_SRC_EXA) |=> VECTOR_ADDR == `FLIC_VEC_EXA)
    else $error("wrong vector for external a");
endmodule : flic_ctrl

// ==== testbench/flic_seq_model.sv ====
// Purpose: instruction sequencer model facing the controller
// Assumes: bench gives length and kind of each next instruction
// Notes: holds still while a call runs
`timescale 1ns/1ps
module flic_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // next instruction
  input wire logic [2:0] nlen,
  input wire logic nret,
  input wire logic nacc,
  // controller side
  input wire logic call,
  output logic last,
  output logic ret,
  output logic acc
);
  logic [2:0] cnt_q;
  logic [2:0] len_q;
  assign last = (cnt_q == len_q) && !call;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 3'h1;
      len_q <= 3'h1;
      ret <= 1'h0;
      acc <= 1'h0;
    end
    else if (last)
    begin
      cnt_q <= 3'h1;
      len_q <= (nlen > 3'h4) ? 3'h4 : nlen;
      ret <= nret;
      acc <= nacc;
    end
    else if (!call)
      cnt_q <= cnt_q + 3'h1;
  end
endmodule : flic_seq_model

// ==== testbench/test_four_level_interrupt_ctrl.sv ====
// Purpose: self-checking bench for the interrupt controller
// Assumes: sequencer model marks instruction boundaries
// Notes: sample phase held high, one sample per cycle
`timescale 1ns/1ps
module test_four_level_interrupt_ctrl;
  // ----------------------
  // signals and instances
  // ----------------------
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic pa_n = 1'h1;
  logic pb_n = 1'h1;
  logic [7:0] en = 8'h00;
  logic [5:0] lo = 6'h00;
  logic [5:0] hi = 6'h00;
  logic [1:0] trig = 2'h0;
  logic [7:0] fl = 8'h00;
  logic [2:0] nlen = 3'h1;
  logic nret = 1'h0;
  logic nacc = 1'h0;
  logic last, ret, acc, call, done, clra, clrb, fa, fb;
  logic [7:0] vec;
  logic [3:0] lis;
  int errors = 0;
  int tests_run = 0;
  int lat;
  int s;
  initial forever #4 clk = ~clk;
  flic_ctrl i_dut (.CORE_CLK(clk), .SYS_RST(rst), .EXT_REQUEST_PIN_A_N(pa_n),
    .EXT_REQUEST_PIN_B_N(pb_n), .SAMPLE_PHASE(1'h1), .SOURCE_ENABLE_REG(en),
    .LOW_PRIORITY_REG(lo), .HIGH_PRIORITY_REG(hi), .TRIGGER_TYPE_BIT(trig),
    .TIMER_A_OVERFLOW_FLAG(fl[1]), .TIMER_B_OVERFLOW_FLAG(fl[3]),
    .SERIAL_RECEIVE_FLAG(fl[4]), .SERIAL_TRANSMIT_FLAG(fl[5]),
    .TIMER_C_OVERFLOW_FLAG(fl[6]), .TIMER_C_EXTERNAL_FLAG(fl[7]),
    .LAST_CYCLE(last), .RETURN_FROM_INTERRUPT(ret), .ENABLE_PRIO_ACCESS(acc),
    .CALL_ACTIVE(call), .CALL_DONE(done), .VECTOR_ADDR(vec), .CLEAR_TIMER_A(clra),
    .CLEAR_TIMER_B(clrb), .EXT_A_REQUEST_FLAG(fa), .EXT_B_REQUEST_FLAG(fb),
    .LEVEL_IN_SERVICE(lis));
  flic_seq_model i_seq (.clk(clk), .rst(rst), .nlen(nlen), .nret(nret), .nacc(nacc),
    .call(call), .last(last), .ret(ret), .acc(acc));
  // ----------------------
  // tasks
  // ----------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic set_req(input int k, input logic v);
    if (k == 0)
      pa_n <= !v;
    else if (k == 2)
      pb_n <= !v;
    else
      fl[k] <= v;
  endtask : set_req
  task automatic wait_call(input int lim);
    lat = 0;
    while (call !== 1'h1 && lat < lim)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask : wait_call
  task automatic serve(input logic [7:0] ev, input logic [1:0] ec);
    wait_call(12);
    check(call, 1'h1);
    check(vec, ev);
    check({clrb, clra}, ec);
    @(posedge clk);
    #1;
    check({call, done}, 2'h3);
    @(posedge clk);
    #1;
    check(call, 1'h0);
  endtask : serve
  task automatic do_ret;
    @(posedge clk);
    nret <= 1'h1;
    @(posedge clk);
    nret <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_ret
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // ----------------------
  // tests
  // ----------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    for (int k = 0; k < 8; k++)
    begin
      s = (k < 4) ? k : ((k < 6) ? 4 : 5);
      @(posedge clk);
      en <= 8'h01 << s;
      set_req(k, 1'h1);
      wait_call(6);
      check(call, 1'h0);
      @(posedge clk);
      en <= 8'h80 | (8'h01 << s);
      serve(8'h03 + 8'(s * 8), {s == 3, s == 1});
      @(posedge clk);
      set_req(k, 1'h0);
      #1;
      check(lis, 4'h1);
      do_ret();
      check(lis, 4'h0);
    end
    $display("test vectors done");
    @(posedge clk);
    en <= 8'hbf;
    set_req(2, 1'h1);
    @(posedge clk);
    set_req(6, 1'h1);
    serve(8'h13, 2'h0);
    @(posedge clk);
    set_req(2, 1'h0);
    wait_call(8);
    check(call, 1'h0);
    @(posedge clk);
    hi <= 6'h08;
    set_req(3, 1'h1);
    serve(8'h1b, 2'h2);
    check(lis, 4'h5);
    @(posedge clk);
    set_req(3, 1'h0);
    do_ret();
    check(lis, 4'h1);
    do_ret();
    serve(8'h2b, 2'h0);
    @(posedge clk);
    set_req(6, 1'h0);
    do_ret();
    @(posedge clk);
    nacc <= 1'h1;
    @(posedge clk);
    nacc <= 1'h0;
    set_req(1, 1'h1);
    repeat (2) @(posedge clk);
    #1;
    check(call, 1'h0);
    serve(8'h0b, 2'h1);
    @(posedge clk);
    set_req(1, 1'h0);
    do_ret();
    $display("test priority done");
    @(posedge clk);
    trig <= 2'h1;
    nlen <= 3'h4;
    en <= 8'h85;
    hi <= 6'h00;
    repeat (3) @(posedge clk);
    pa_n <= 1'h0;
    pb_n <= 1'h0;
    wait_call(12);
    check(lat >= 2 && lat <= 6, 1'h1);
    check(vec, 8'h03);
    repeat (3) @(posedge clk);
    #1;
    check({fb, fa}, 2'h2);
    $display("test latency done");
    results();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    results();
  end
endmodule : test_four_level_interrupt_ctrl
